//--- common/ifa_pkg.sv
// package for the indirect file access alu slice
// What this block does
// RULE_01 - an access to the indirect window register reaches the data location held in the pointer.
// RULE_02 - reading the window while the pointer is zero returns 00h.
// RULE_03 - writing the window while it points at itself changes no storage, flags may still change.
// RULE_04 - the pointer is 5 bits wide without banking and 7 bits wide with banking.
// RULE_05 - pointer bits 4 to 0 select location 00h to 1Fh within the bank.
// RULE_06 - without banking, pointer bits 6 and 5 read back as ones.
// RULE_07 - with banking, pointer bits 6 and 5 pick one of four banks, 00 to 11 for banks 0 to 3.
// RULE_08 - or_literal_op (1101 kkkk kkkk) ors the accumulator with k into the accumulator, sets zero, one cycle.
// RULE_09 - or_file_op (0001 00df ffff) ors the accumulator with f, result to accumulator if d=0 else f, sets zero.
// RULE_10 - move_file_op (0010 00df ffff) copies f to accumulator if d=0 else back to f, sets zero.
// RULE_11 - move_literal_op (1100 kkkk kkkk) loads k into the accumulator and leaves the flags alone.
// RULE_12 - every instruction word is 12 bits and takes one cycle, branches two.
// RULE_13 - the zero flag is set when an 8-bit result is zero and cleared otherwise.
// RULE_14 - a file operand of zero means the window register, so the pointer gives the address.
package ifa_pkg;
  localparam int unsigned IW = 12;
  localparam int unsigned DW = 8;
  localparam int unsigned PW = 7;
  localparam int unsigned AW = 7;
  localparam int unsigned HAW = 8;
  // register byte addresses on the bus
  localparam logic [HAW-1:0] A_INSTR  = 8'h00;
  localparam logic [HAW-1:0] A_ACC    = 8'h04;
  localparam logic [HAW-1:0] A_PTR    = 8'h08;
  localparam logic [HAW-1:0] A_STATUS = 8'h0C;
  localparam logic [HAW-1:0] A_CTRL   = 8'h10;
  localparam logic [HAW-1:0] A_MEM    = 8'h80;
  localparam logic [1:0]     HT_NONSEQ = 2'h2;
  localparam logic [1:0]     HT_SEQ    = 2'h3;
  // opcode fields
  localparam logic [3:0] OP_ORL  = 4'hD;
  localparam logic [3:0] OP_MOVL = 4'hC;
  localparam logic [5:0] OP_ORF  = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE_OP = 6'h08;
  localparam int unsigned D_BIT = 5;
  localparam logic [4:0] F_WINDOW = 5'h00;
  localparam logic [1:0] UNBANKED_HI = 2'h3;
  localparam logic [PW-1:0] PTR_RST = 7'h00;
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam int unsigned CTRL_BANKED = 0;
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_ILLEGAL = 1;
  localparam int unsigned ST_NOSTORE = 2;
  localparam int unsigned MEM_WORDS = 128;
  typedef enum logic [1:0] {
    IFA_IDLE = 2'b00,
    IFA_READ = 2'b01,
    IFA_EXEC = 2'b10
  } ifa_state_t;
endpackage : ifa_pkg

//--- common/ifa_mem_if.sv
// memory port bundle between core and data memory
`timescale 1ns/1ps
interface ifa_mem_if;
  import ifa_pkg::*;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport core (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : ifa_mem_if

//--- logic/ifa_mem.sv
// data memory of four banks, registered read data
`timescale 1ns/1ps
module ifa_mem (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory port
  ifa_mem_if.mem   mp
);
  import ifa_pkg::*;
  logic [DW-1:0] ram [MEM_WORDS];
  logic [DW-1:0] rd_q;
  // no reset on the array so it maps to plain ram
  always_ff @(posedge hclk) begin
    if (mp.we) begin
      ram[mp.addr] <= mp.wdata;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= '0;
    end else begin
      rd_q <= ram[mp.addr];
    end
  end
  assign mp.rdata = rd_q;
endmodule : ifa_mem

//--- logic/ifa_core.sv
// indirect file access alu slice with ahb-lite register port
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module ifa_core (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp
);
  import ifa_pkg::*;

  typedef struct packed {
    ifa_state_t    st;
    logic          wr;
    logic [HAW-1:0] adr;
    logic [IW-1:0] ins;
    logic [DW-1:0] acc;
    logic [PW-1:0] ptr;
    logic          banked;
    logic [2:0]    status;
    logic [AW-1:0] maddr;
    logic          mwe;
    logic [DW-1:0] mwd;
    logic [31:0]   rdata;
    logic          ready;
  } ifa_regs_t;

  ifa_regs_t r_q, r_d;
  ifa_mem_if mif ();

  ifa_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .mp      (mif)
  );

  assign mif.we    = r_q.mwe;
  // ram registers its read, so it is handed the next address one cycle early
  assign mif.addr  = r_d.maddr;
  assign mif.wdata = r_q.mwd;

  logic [DW-1:0] ptr_view;
  logic [4:0]    f_fld;
  logic          f_is_win;
  logic          f_is_ptr;
  logic          self_ref;
  logic [AW-1:0] eff_addr;
  logic [DW-1:0] opnd;
  logic [DW-1:0] res;
  logic          dst_f;
  logic          is_orf;
  logic          is_move_file_op;
  logic          is_orl;
  logic          is_movl;
  logic [HAW-1:0] bus_a;

  always_comb begin
    ptr_view = {1'b0, r_q.ptr};
    if (!r_q.banked) begin
      ptr_view[6:5] = UNBANKED_HI; // RULE_06
    end
    f_fld    = r_q.ins[4:0];
    dst_f    = r_q.ins[D_BIT];
    is_orl   = r_q.ins[11:8] == OP_ORL;                    // RULE_08
    is_movl  = r_q.ins[11:8] == OP_MOVL;                   // RULE_11
    is_orf   = r_q.ins[11:6] == OP_ORF;                    // RULE_09
    is_move_file_op  = r_q.ins[11:6] == OP_MOVE_FILE_OP;                   // RULE_10
    f_is_win = f_fld == F_WINDOW;                          // RULE_14
    self_ref = f_is_win && (r_q.ptr[4:0] == 5'h00);        // RULE_02
    // pointer is a file slot of its own, kept out of the ram
    f_is_ptr = !f_is_win && (f_fld == 5'h04);
    if (f_is_win) begin
      // banked parts steer bank bits 6:5, plain parts stay in bank 0
      eff_addr = r_q.banked ? r_q.ptr : {2'b00, r_q.ptr[4:0]}; // RULE_01 RULE_05 RULE_07
    end else begin
      eff_addr = {2'b00, f_fld};
    end
    if (self_ref) begin
      opnd = 8'h00; // RULE_02
    end else if (f_is_ptr) begin
      opnd = ptr_view;
    end else begin
      opnd = mif.rdata;
    end
    res = is_move_file_op ? opnd : (r_q.acc | (is_orl ? r_q.ins[7:0] : opnd));
    bus_a = haddr[HAW-1:0];
  end

  always_comb begin
    r_d       = r_q;
    r_d.mwe   = 1'b0;
    r_d.ready = 1'b1;
    case (r_q.st)
      IFA_IDLE: begin
        if (hsel && hready && (htrans == HT_NONSEQ || htrans == HT_SEQ)) begin
          r_d.wr  = hwrite;
          r_d.adr = bus_a;
          r_d.ready = 1'b0;
          r_d.st  = IFA_READ;
        end
      end
      IFA_READ: begin
        r_d.st    = IFA_IDLE;
        r_d.rdata = '0;
        if (r_q.wr) begin
          if (r_q.adr == A_INSTR) begin
            r_d.ins   = hwdata[IW-1:0]; // RULE_12
            r_d.maddr = (hwdata[4:0] == F_WINDOW) ?
                        (r_q.banked ? r_q.ptr : {2'b00, r_q.ptr[4:0]}) :
                        {2'b00, hwdata[4:0]};
            r_d.ready = 1'b0;
            r_d.st    = IFA_EXEC;
          end else if (r_q.adr == A_ACC) begin
            r_d.acc = hwdata[DW-1:0];
          end else if (r_q.adr == A_PTR) begin
            r_d.ptr = r_q.banked ? hwdata[PW-1:0] : {2'b00, hwdata[4:0]}; // RULE_04
          end else if (r_q.adr == A_STATUS) begin
            r_d.status = r_q.status & ~hwdata[2:0];
          end else if (r_q.adr == A_CTRL) begin
            r_d.banked = hwdata[CTRL_BANKED];
          end else if (r_q.adr >= A_MEM) begin
            r_d.maddr = {2'b00, r_q.adr[6:2]};
            r_d.mwd   = hwdata[DW-1:0];
            r_d.mwe   = 1'b1;
          end
        end else begin
          if (r_q.adr == A_INSTR) begin
            r_d.rdata = {20'h00000, r_q.ins};
          end else if (r_q.adr == A_ACC) begin
            r_d.rdata = {24'h000000, r_q.acc};
          end else if (r_q.adr == A_PTR) begin
            r_d.rdata = {24'h000000, ptr_view}; // RULE_06
          end else if (r_q.adr == A_STATUS) begin
            r_d.rdata = {29'h0, r_q.status};
          end else if (r_q.adr == A_CTRL) begin
            r_d.rdata = {31'h0, r_q.banked};
          end else if (r_q.adr >= A_MEM) begin
            r_d.maddr = {2'b00, r_q.adr[6:2]};
            r_d.ready = 1'b0;
            r_d.st    = IFA_EXEC;
          end
        end
      end
      IFA_EXEC: begin
        // one core cycle, memory operand already registered
        r_d.st = IFA_IDLE;
        if (r_q.adr != A_INSTR) begin
          r_d.rdata = {24'h000000, mif.rdata};
        end else if (is_movl) begin
          r_d.acc = r_q.ins[7:0]; // RULE_11
        end else if (is_orl || is_orf || is_move_file_op) begin
          r_d.status[ST_ZERO] = res == 8'h00; // RULE_13
          if ((is_orf || is_move_file_op) && dst_f) begin
            if (self_ref) begin
              r_d.status[ST_NOSTORE] = 1'b1; // RULE_03
            end else if (f_is_ptr) begin
              r_d.ptr = r_q.banked ? res[PW-1:0] : {2'b00, res[4:0]};
            end else begin
              r_d.maddr = eff_addr; // RULE_01
              r_d.mwd   = res;      // RULE_09 RULE_10
              r_d.mwe   = 1'b1;
            end
          end else begin
            r_d.acc = res; // RULE_08 RULE_09 RULE_10
          end
        end else begin
          r_d.status[ST_ILLEGAL] = 1'b1;
        end
      end
      default: begin
        r_d.st = IFA_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q        <= '0;
      r_q.st     <= IFA_IDLE;
      r_q.acc    <= ACC_RST;
      r_q.ptr    <= PTR_RST;
      r_q.ready  <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign hrdata    = r_q.rdata;
  assign hreadyout = r_q.ready;
  assign hresp     = 1'b0;
endmodule : ifa_core

//--- test/ifa_properties.sv
// port timing and read data properties of the alu slice register port
`timescale 1ns/1ps
module ifa_properties import ifa_pkg::*; (
  // bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic [7:0] a_q;
  logic       w_q;
  assign take = hsel && hready && htrans[1];
  // last accepted address, so a completed read can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 8'h00;
      w_q <= 1'b1;
    end else if (take) begin
      a_q <= haddr[7:0];
      w_q <= hwrite;
    end
  end
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_two_wait; !hreadyout[*2] ##1 hreadyout; endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_instr_exec: assert property (take && hwrite && haddr[7:0] == A_INSTR |=> s_two_wait)
    else $error("instruction write timing wrong");
  a_acc_access: assert property (take && haddr[7:0] == A_ACC |=> s_one_wait)
    else $error("accumulator access timing wrong");
  a_ptr_access: assert property (take && haddr[7:0] == A_PTR |=> s_one_wait)
    else $error("pointer access timing wrong");
  a_mem_read: assert property (take && !hwrite && haddr[7] |=> s_two_wait)
    else $error("data read timing wrong");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved while idle");
  a_unmapped_zero: assert property ($rose(hreadyout) && !w_q && !a_q[7] && a_q > A_CTRL
    |-> hrdata == 32'h0) else $error("unmapped read not zero");
  a_ptr_width: assert property ($rose(hreadyout) && !w_q && a_q == A_PTR
    |-> hrdata[31:7] == 25'h0) else $error("pointer wider than seven bits");
endmodule : ifa_properties
bind ifa_core ifa_properties u_ifa_properties (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

//--- test/indirect_file_access_alu_subset_tb.sv
// self-checking bench of the alu slice over its register port
`timescale 1ns/1ps
module indirect_file_access_alu_subset_tb;
  import ifa_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, z = 0, d;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [7:0]  acc, v, k, loc;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  always #12.5 hclk = ~hclk;
  // one slave, so its ready is the bus ready
  ifa_core u_ifa_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  task end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // holds address phase, then data phase, until ready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
    haddr <= {24'h0, a}; hwrite <= w; htrans <= HT_NONSEQ; hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= dt;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task rd(input logic [7:0] a); xfer(1'b0, a, 32'h0); endtask : rd
  task op(input logic [11:0] i); xfer(1'b1, A_INSTR, {20'h0, i}); endtask : op
  task stz; rd(A_STATUS); chk({31'h0, r[0]}, {31'h0, z}); endtask : stz
  task rda(input logic [7:0] e); rd(A_ACC); chk(r, {24'h0, e}); endtask : rda
  function logic [8:0] res(input logic [7:0] x); return {x == 8'h00, x}; endfunction : res
  initial begin
    void'($urandom(32'hF26FE334));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rda(8'h00);
    rd(A_PTR); chk(r, 32'h60);
    xfer(1'b1, A_PTR, 32'h05); rd(A_PTR); chk(r, 32'h65);
    rd(8'h14); chk(r, 32'h0);
    xfer(1'b1, A_CTRL, 32'h1);
    xfer(1'b1, A_PTR, 32'h45); rd(A_PTR); chk(r, 32'h45);
    for (int i = 0; i < 10; i++) begin
      loc = 8'h08 + 8'($urandom % 16);
      v = (i == 0) ? 8'h00 : 8'($urandom);
      k = (i == 0) ? 8'h00 : 8'($urandom);
      d = 1'($urandom);
      xfer(1'b1, A_MEM | {loc[5:0], 2'b00}, {24'h0, v});
      op({OP_MOVL, k}); acc = k; rda(acc); stz();
      op({OP_ORF, d, loc[4:0]}); {z, k} = res(acc | v);
      if (d) v = k; else acc = k;
      rda(acc); stz();
      rd(A_MEM | {loc[5:0], 2'b00}); chk(r, {24'h0, v});
      op({OP_MOVE_FILE_OP, d, loc[4:0]}); z = (v == 8'h00);
      if (!d) acc = v;
      rda(acc); stz();
      k = 8'($urandom);
      op({OP_ORL, k}); {z, acc} = res(acc | k); rda(acc); stz();
      xfer(1'b1, A_PTR, {24'h0, loc});
      op({OP_MOVE_FILE_OP, 1'b0, F_WINDOW}); acc = v; z = (v == 8'h00); rda(acc);
    end
    // unknown bank one cell is forced known by or-ing all ones into it
    op({OP_MOVL, 8'hFF});
    xfer(1'b1, A_PTR, {24'h0, loc | 8'h20}); op({OP_ORF, 1'b1, F_WINDOW});
    xfer(1'b1, A_PTR, {24'h0, loc}); op({OP_MOVE_FILE_OP, 1'b0, F_WINDOW}); rda(v);
    xfer(1'b1, A_PTR, {24'h0, loc | 8'h20}); op({OP_MOVE_FILE_OP, 1'b0, F_WINDOW}); rda(8'hFF);
    xfer(1'b1, A_PTR, 32'h0); op({OP_MOVL, 8'h5A}); op({OP_ORF, 1'b1, F_WINDOW});
    rd(A_PTR); chk(r, 32'h0); rda(8'h5A);
    rd(A_STATUS); chk(r, 32'h4);
    xfer(1'b1, A_STATUS, 32'h7); rd(A_STATUS); chk(r, 32'h0);
    op({OP_MOVE_FILE_OP, 1'b0, F_WINDOW}); z = 1'b1; rda(8'h00); stz();
    op(12'hF00); rda(8'h00); rd(A_STATUS); chk(r, 32'h3);
    end_sim();
  end
endmodule : indirect_file_access_alu_subset_tb
